/* File: pkg/mbs_regs.vh */
`ifndef MBS_REGS_VH
`define MBS_REGS_VH

// Timing.
`define MBS_CLK_PERIOD_NS  100
`define MBS_SETTLE_NS      10000
`define MBS_SETTLE_CYC     ((`MBS_SETTLE_NS + `MBS_CLK_PERIOD_NS - 1) / `MBS_CLK_PERIOD_NS)

// Management register map of the MAC, 12-bit byte addresses.
`define MBS_MDIO_CFG       12'h500
`define MBS_MDIO_CTRL      12'h504
`define MBS_MDIO_TX        12'h508
`define MBS_MDIO_RX        12'h50C
`define MBS_MAC_SPEED      12'h410
`define MBS_FC_TX          12'h408
`define MBS_FC_RX          12'h40C
`define MBS_UC_ADDR0       12'h700
`define MBS_UC_ADDR1       12'h704
`define MBS_FILT_MODE      12'h708
`define MBS_FILT_BASE      12'h710
`define MBS_RTC_CTRL       12'h800
`define MBS_PTP_TX         12'h804
`define MBS_PTP_STAT       12'h808

// Field positions and values.
`define MBS_MDIO_EN_BIT    6
`define MBS_MDIO_DIV       32'h00000013
`define MBS_MDIO_PHY_POS   24
`define MBS_MDIO_REG_POS   16
`define MBS_MDIO_OP_POS    14
`define MBS_MDIO_GO_BIT    11
`define MBS_MDIO_RDY_BIT   7
`define MBS_MDIO_OP_WR     2'h1
`define MBS_MDIO_OP_RD     2'h2
`define MBS_PHY_LOC        5'h07
`define MBS_PRB_REG        5'h02
`define MBS_ADV_REG        5'h04
`define MBS_GIG_REG        5'h09
`define MBS_RGM_REG        5'h14
`define MBS_CTL_REG        5'h00
`define MBS_STS_REG        5'h01
`define MBS_ADV_10         32'h00000061
`define MBS_ADV_100        32'h00000181
`define MBS_ADV_1G         32'h00000001
`define MBS_GIG_ADV_1G     32'h00000200
`define MBS_RGM_SEL        32'h00000008
`define MBS_PHY_RST_AN     32'h00009200
`define MBS_AN_DONE_BIT    5
`define MBS_SPEED_POS      30
`define MBS_FC_OFF         32'h10000000
`define MBS_PROMISC_BIT    31
`define MBS_FILT_VAL       96'h06050403025A0605040302DA
`define MBS_FILT_MASK      32'hFFFFFFFF
`define MBS_UC_WORD0       32'h040302DA
`define MBS_UC_WORD1       32'h00000605
`define MBS_RTC_START      32'h00000001
`define MBS_PTP_SEND       32'h00000001
`define MBS_PTP_RX_BIT     0

// Wishbone register offsets and fields.
`define MBS_WB_CTRL        8'h00
`define MBS_WB_STAT        8'h04
`define MBS_CTRL_UPD_BIT   0
`define MBS_CTRL_SBLK_BIT  1
`define MBS_CTRL_RESET     1'h0

// Serial frame layout.
`define MBS_SER_AW         12
`define MBS_SER_CMD_BITS   45
`define MBS_SER_RSP_BITS   32

`endif

/* File: rtl/mbs_serial.v */
`timescale 1ns/100ps
`default_nettype none
`include "mbs_regs.vh"

// Bit-per-clock serial port: a 1 start bit, then we, address and data, MSB first.
module mbs_serial (
  input  wire                    clock,
  input  wire                    rst,
  input  wire                    ser_in,
  output wire                    ser_out,
  output reg                     cmd_valid,
  output reg                     cmd_we,
  output reg  [`MBS_SER_AW-1:0]  cmd_addr,
  output reg  [31:0]             cmd_wdata,
  input  wire                    cmd_take,
  input  wire                    rsp_load,
  input  wire [31:0]             rsp_data
);
  reg [44:0] sh_q;
  reg [5:0]  icnt_q;
  reg        ibusy_q;
  reg [32:0] osh_q;
  reg [5:0]  ocnt_q;

  assign ser_out = osh_q[32];

  always @(posedge clock) begin
    if (rst) begin
      sh_q      <= 45'h0;
      icnt_q    <= 6'h0;
      ibusy_q   <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_we    <= 1'b0;
      cmd_addr  <= 12'h000;
      cmd_wdata <= 32'h0;
      osh_q     <= 33'h0;
      ocnt_q    <= 6'h0;
    end else begin
      if (cmd_take)
        cmd_valid <= 1'b0;
      // A frame that starts while a command is still pending is not sampled.
      if (!ibusy_q && !cmd_valid && ser_in) begin // R13
        ibusy_q <= 1'b1;
        icnt_q  <= 6'h0;
      end else if (ibusy_q) begin
        sh_q   <= {sh_q[43:0], ser_in};
        icnt_q <= icnt_q + 6'h1;
        if (icnt_q == `MBS_SER_CMD_BITS - 1) begin
          ibusy_q   <= 1'b0;
          cmd_valid <= 1'b1;
          cmd_we    <= sh_q[43];
          cmd_addr  <= sh_q[42:31];
          cmd_wdata <= {sh_q[30:0], ser_in};
        end
      end
      if (rsp_load) begin // R13
        osh_q  <= {1'b1, rsp_data};
        ocnt_q <= 6'h21;
      end else if (ocnt_q != 6'h0) begin
        osh_q  <= {osh_q[31:0], 1'b0};
        ocnt_q <= ocnt_q - 6'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/mbs_sequencer.v */
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "mbs_regs.vh"

// Notes on behaviour
// R1 - After reset it waits for internal resets to settle, then enables MDIO with the divider.
// R2 - With MDIO enabled it reads PHY bus location 7 to probe for a PHY.
// R3 - An all-ones probe result means no PHY and every later MDIO access is skipped.
// R4 - With a PHY present it writes the speed advertisement chosen by the speed inputs.
// R5 - In RGMII builds whose PHY is not RGMII-only it read-modify-writes a PHY register.
// R6 - After PHY setup it resets the PHY and restarts auto-negotiation.
// R7 - Once auto-negotiation completes it programs the MAC speed from the speed inputs.
// R8 - It then writes the MAC configuration with flow control disabled.
// R9 - With the filter built in it loads value and mask bytes 11..0, promiscuous only with a PHY.
// R10 - Without the filter it loads the unicast address and sets promiscuous mode.
// R11 - With AVB present it starts the time clock, then sends and awaits PTP frames.
// R12 - It idles afterwards and a speed update recaptures speed and restarts at the probe.
// R13 - A serial command input and response output give read or write of any location.
// R14 - The sequencer only acts in builds with the lite memory-mapped management port.
// R15 - Only one management transaction is in flight, each finished before the next.
module mbs_sequencer #(
  parameter LITE_MGMT  = 1,
  parameter FILTER_EN  = 1,
  parameter AVB_EN     = 0,
  parameter RGMII_EN   = 0,
  parameter RGMII_ONLY = 0
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [1:0]  mac_speed,
  input  wire        update_speed,
  input  wire        serial_command,
  output wire        serial_response,
  input  wire        wb_cyc,
  input  wire        wb_stb,
  input  wire        wb_we,
  input  wire [7:0]  wb_adr,
  input  wire [3:0]  wb_sel,
  input  wire [31:0] wb_dat_w,
  output reg  [31:0] wb_dat_r,
  output reg         wb_ack,
  output reg  [11:0] m_awaddr,
  output reg         m_awvalid,
  input  wire        m_awready,
  output reg  [31:0] m_wdata,
  output reg         m_wvalid,
  input  wire        m_wready,
  input  wire [1:0]  m_bresp,
  input  wire        m_bvalid,
  output wire        m_bready,
  output reg  [11:0] m_araddr,
  output reg         m_arvalid,
  input  wire        m_arready,
  input  wire [31:0] m_rdata,
  input  wire [1:0]  m_rresp,
  input  wire        m_rvalid,
  output wire        m_rready
);
  localparam [7:0] S_SETTLE = 8'h01, S_ISSUE = 8'h02, S_WR = 8'h04, S_B = 8'h08,
                   S_RD = 8'h10, S_R = 8'h20, S_IDLE = 8'h40, S_OFF = 8'h80;
  localparam [5:0] ST_EN = 6'd0, ST_PRB_C = 6'd1, ST_PRB_P = 6'd2, ST_PRB_D = 6'd3,
                   ST_ADV_T = 6'd4, ST_ADV_C = 6'd5, ST_ADV_P = 6'd6, ST_GIG_T = 6'd7,
                   ST_GIG_C = 6'd8, ST_GIG_P = 6'd9, ST_RG_C = 6'd10, ST_RG_P = 6'd11,
                   ST_RG_D = 6'd12, ST_RG_T = 6'd13, ST_RG_W = 6'd14, ST_RG_WP = 6'd15,
                   ST_RST_T = 6'd16, ST_RST_C = 6'd17, ST_RST_P = 6'd18, ST_AN_C = 6'd19,
                   ST_AN_P = 6'd20, ST_AN_D = 6'd21, ST_SPD = 6'd22, ST_FC_TX = 6'd23,
                   ST_FC_RX = 6'd24, ST_FLT = 6'd25, ST_FMODE = 6'd26, ST_UC0 = 6'd27,
                   ST_UC1 = 6'd28, ST_UMODE = 6'd29, ST_RTC = 6'd30, ST_PTP_T = 6'd31,
                   ST_PTP_R = 6'd32, ST_DONE = 6'd33;
  localparam [15:0] SETTLE_CYC = `MBS_SETTLE_CYC;
  localparam [95:0] FILT_VAL   = `MBS_FILT_VAL;

  function [31:0] mdio_word;
    input [1:0] op;
    input [4:0] reg_num;
    begin
      mdio_word = ({27'h0, `MBS_PHY_LOC} << `MBS_MDIO_PHY_POS)
                | ({27'h0, reg_num} << `MBS_MDIO_REG_POS)
                | ({30'h0, op} << `MBS_MDIO_OP_POS)
                | (32'h1 << `MBS_MDIO_GO_BIT);
    end
  endfunction

  function [31:0] filt_word;
    input [2:0] idx;
    begin
      case (idx)
        3'd0:    filt_word = FILT_VAL[31:0];
        3'd1:    filt_word = FILT_VAL[63:32];
        3'd2:    filt_word = FILT_VAL[95:64];
        default: filt_word = `MBS_FILT_MASK;
      endcase
    end
  endfunction

  reg  [3:0]  sy1_q;
  reg  [3:0]  sy2_q;
  reg         upd_old_q;
  reg  [7:0]  state_q;
  reg  [5:0]  step_q;
  reg  [5:0]  nxt;
  reg  [15:0] wait_q;
  reg  [1:0]  speed_q;
  reg         phy_q;
  reg         done_q;
  reg         rsp_err_q;
  reg         upd_pend_q;
  reg         ser_q;
  reg         sblk_q;
  reg  [2:0]  fidx_q;
  reg  [15:0] rg_q;
  reg         op_rd;
  reg  [11:0] op_addr;
  reg  [31:0] op_data;
  wire        cmd_valid;
  wire        cmd_we;
  wire [11:0] cmd_addr;
  wire [31:0] cmd_wdata;
  wire        wb_hit;
  wire        wb_upd;
  wire        upd_edge;
  wire        fin;
  wire        take_cmd;

  // Pin inputs pass two flops; only the second stage is read.
  always @(posedge clock) begin
    if (rst) begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
    end else begin
      sy1_q <= {serial_command, update_speed, mac_speed};
      sy2_q <= sy1_q;
    end
  end

  assign upd_edge = sy2_q[2] & ~upd_old_q;
  assign wb_hit   = wb_cyc & wb_stb & ~wb_ack;
  assign wb_upd   = wb_hit & wb_we & wb_sel[0] & (wb_adr == `MBS_WB_CTRL)
                  & wb_dat_w[`MBS_CTRL_UPD_BIT];
  assign m_bready = state_q == S_B;
  assign m_rready = state_q == S_R;
  assign fin      = (state_q == S_B && m_bvalid) || (state_q == S_R && m_rvalid); // R15
  assign take_cmd = state_q == S_IDLE && cmd_valid && !sblk_q && !upd_pend_q;

  mbs_serial u_serial (
    .clock     (clock),
    .rst       (rst),
    .ser_in    (sy2_q[3]),
    .ser_out   (serial_response),
    .cmd_valid (cmd_valid),
    .cmd_we    (cmd_we),
    .cmd_addr  (cmd_addr),
    .cmd_wdata (cmd_wdata),
    .cmd_take  (take_cmd),
    .rsp_load  (fin && ser_q),
    .rsp_data  (m_rvalid && state_q == S_R ? m_rdata : 32'h0)
  );

  // Access issued for the current step.
  always @* begin
    op_rd   = 1'b0;
    op_addr = `MBS_MDIO_TX;
    op_data = 32'h0;
    case (step_q)
      ST_EN: begin
        op_addr = `MBS_MDIO_CFG; // R1
        op_data = `MBS_MDIO_DIV | (32'h1 << `MBS_MDIO_EN_BIT);
      end
      ST_PRB_C: begin
        op_addr = `MBS_MDIO_CTRL; // R2
        op_data = mdio_word(`MBS_MDIO_OP_RD, `MBS_PRB_REG);
      end
      ST_PRB_P, ST_ADV_P, ST_GIG_P, ST_RG_P, ST_RG_WP, ST_RST_P, ST_AN_P: begin
        op_rd   = 1'b1;
        op_addr = `MBS_MDIO_CTRL;
      end
      ST_PRB_D, ST_RG_D, ST_AN_D: begin
        op_rd   = 1'b1;
        op_addr = `MBS_MDIO_RX;
      end
      ST_ADV_T: begin
        case (speed_q) // R4
          2'b10:   op_data = `MBS_ADV_1G;
          2'b01:   op_data = `MBS_ADV_100;
          default: op_data = `MBS_ADV_10;
        endcase
      end
      ST_ADV_C: begin
        op_addr = `MBS_MDIO_CTRL;
        op_data = mdio_word(`MBS_MDIO_OP_WR, `MBS_ADV_REG);
      end
      ST_GIG_T: op_data = (speed_q == 2'b10) ? `MBS_GIG_ADV_1G : 32'h0; // R4
      ST_GIG_C: begin
        op_addr = `MBS_MDIO_CTRL;
        op_data = mdio_word(`MBS_MDIO_OP_WR, `MBS_GIG_REG);
      end
      ST_RG_C: begin
        op_addr = `MBS_MDIO_CTRL;
        op_data = mdio_word(`MBS_MDIO_OP_RD, `MBS_RGM_REG);
      end
      ST_RG_T: op_data = {16'h0, rg_q} | `MBS_RGM_SEL; // R5
      ST_RG_W: begin
        op_addr = `MBS_MDIO_CTRL;
        op_data = mdio_word(`MBS_MDIO_OP_WR, `MBS_RGM_REG);
      end
      ST_RST_T: op_data = `MBS_PHY_RST_AN; // R6
      ST_RST_C: begin
        op_addr = `MBS_MDIO_CTRL;
        op_data = mdio_word(`MBS_MDIO_OP_WR, `MBS_CTL_REG);
      end
      ST_AN_C: begin
        op_addr = `MBS_MDIO_CTRL;
        op_data = mdio_word(`MBS_MDIO_OP_RD, `MBS_STS_REG);
      end
      ST_SPD: begin
        op_addr = `MBS_MAC_SPEED; // R7
        op_data = {speed_q, 30'h0};
      end
      ST_FC_TX: begin
        op_addr = `MBS_FC_TX; // R8
        op_data = `MBS_FC_OFF;
      end
      ST_FC_RX: begin
        op_addr = `MBS_FC_RX; // R8
        op_data = `MBS_FC_OFF;
      end
      ST_FLT: begin
        op_addr = `MBS_FILT_BASE + {7'h0, fidx_q, 2'b00}; // R9
        op_data = filt_word(fidx_q);
      end
      ST_FMODE: begin
        op_addr = `MBS_FILT_MODE;
        op_data = {phy_q, 31'h0}; // R9
      end
      ST_UC0: begin
        op_addr = `MBS_UC_ADDR0; // R10
        op_data = `MBS_UC_WORD0;
      end
      ST_UC1: begin
        op_addr = `MBS_UC_ADDR1;
        op_data = `MBS_UC_WORD1;
      end
      ST_UMODE: begin
        op_addr = `MBS_FILT_MODE;
        op_data = 32'h1 << `MBS_PROMISC_BIT; // R10
      end
      ST_RTC: begin
        op_addr = `MBS_RTC_CTRL; // R11
        op_data = `MBS_RTC_START;
      end
      ST_PTP_T: begin
        op_addr = `MBS_PTP_TX; // R11
        op_data = `MBS_PTP_SEND;
      end
      ST_PTP_R: begin
        op_rd   = 1'b1;
        op_addr = `MBS_PTP_STAT;
      end
      default: op_data = 32'h0;
    endcase
  end

  // Step that follows a finished access; polls repeat until their bit is seen.
  always @* begin
    nxt = step_q + 6'd1;
    case (step_q)
      ST_PRB_P, ST_ADV_P, ST_GIG_P, ST_RG_P, ST_RG_WP, ST_RST_P, ST_AN_P:
        if (!m_rdata[`MBS_MDIO_RDY_BIT])
          nxt = step_q;
        else if (step_q == ST_GIG_P && !(RGMII_EN != 0 && RGMII_ONLY == 0))
          nxt = ST_RST_T; // R5
      ST_PRB_D: if (m_rdata[15:0] == 16'hFFFF) nxt = ST_SPD; // R3
      ST_AN_D: if (!m_rdata[`MBS_AN_DONE_BIT]) nxt = ST_AN_C; // R7
      ST_FC_RX: nxt = (FILTER_EN != 0) ? ST_FLT : ST_UC0;
      ST_FLT: if (fidx_q != 3'd5) nxt = ST_FLT;
      ST_FMODE, ST_UMODE: nxt = (AVB_EN != 0) ? ST_RTC : ST_DONE; // R11
      ST_PTP_R: if (!m_rdata[`MBS_PTP_RX_BIT]) nxt = ST_PTP_R;
      default: nxt = step_q + 6'd1;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state_q    <= S_SETTLE;
      step_q     <= ST_EN;
      wait_q     <= 16'h0;
      speed_q    <= 2'b00;
      phy_q      <= 1'b0;
      done_q     <= 1'b0;
      rsp_err_q  <= 1'b0;
      upd_pend_q <= 1'b0;
      upd_old_q  <= 1'b0;
      ser_q      <= 1'b0;
      fidx_q     <= 3'd0;
      rg_q       <= 16'h0;
      m_awaddr   <= 12'h000;
      m_awvalid  <= 1'b0;
      m_wdata    <= 32'h0;
      m_wvalid   <= 1'b0;
      m_araddr   <= 12'h000;
      m_arvalid  <= 1'b0;
    end else begin
      upd_old_q <= sy2_q[2];
      // A request arriving as the idle state consumes the last one is kept.
      if (upd_edge || wb_upd)
        upd_pend_q <= 1'b1; // R12
      else if (state_q == S_IDLE && !cmd_valid)
        upd_pend_q <= 1'b0;
      else if (state_q == S_IDLE && upd_pend_q)
        upd_pend_q <= 1'b0;
      case (state_q)
        S_SETTLE: begin
          wait_q <= wait_q + 16'h1;
          if (wait_q == SETTLE_CYC - 16'h1) begin // R1
            state_q <= (LITE_MGMT != 0) ? S_ISSUE : S_OFF; // R14
            speed_q <= sy2_q[1:0];
          end
        end
        S_ISSUE: begin
          if (step_q == ST_DONE) begin
            state_q <= S_IDLE; // R12
            done_q  <= 1'b1;
          end else if (op_rd) begin
            m_araddr  <= op_addr;
            m_arvalid <= 1'b1;
            state_q   <= S_RD;
          end else begin
            m_awaddr  <= op_addr;
            m_wdata   <= op_data;
            m_awvalid <= 1'b1;
            m_wvalid  <= 1'b1;
            state_q   <= S_WR;
          end
        end
        S_WR: begin
          if (m_awready)
            m_awvalid <= 1'b0;
          if (m_wready)
            m_wvalid <= 1'b0;
          if ((m_awready || !m_awvalid) && (m_wready || !m_wvalid))
            state_q <= S_B;
        end
        S_RD: begin
          if (m_arready) begin
            m_arvalid <= 1'b0;
            state_q   <= S_R;
          end
        end
        S_B, S_R: begin
          if (fin) begin
            if ((state_q == S_B ? m_bresp : m_rresp) != 2'b00)
              rsp_err_q <= 1'b1;
            if (ser_q) begin
              ser_q   <= 1'b0;
              state_q <= S_IDLE;
            end else begin
              state_q <= S_ISSUE;
              step_q  <= nxt;
              if (step_q == ST_PRB_D)
                phy_q <= m_rdata[15:0] != 16'hFFFF; // R3
              if (step_q == ST_RG_D)
                rg_q <= m_rdata[15:0]; // R5
              if (step_q == ST_FLT)
                fidx_q <= fidx_q + 3'd1;
            end
          end
        end
        S_IDLE: begin
          if (upd_pend_q) begin
            speed_q <= sy2_q[1:0]; // R12
            step_q  <= ST_PRB_C;
            fidx_q  <= 3'd0;
            done_q  <= 1'b0;
            state_q <= S_ISSUE;
          end else if (take_cmd) begin
            ser_q <= 1'b1; // R13
            if (cmd_we) begin
              m_awaddr  <= cmd_addr;
              m_wdata   <= cmd_wdata;
              m_awvalid <= 1'b1;
              m_wvalid  <= 1'b1;
              state_q   <= S_WR;
            end else begin
              m_araddr  <= cmd_addr;
              m_arvalid <= 1'b1;
              state_q   <= S_RD;
            end
          end
        end
        S_OFF: state_q <= S_OFF;
        default: state_q <= S_SETTLE;
      endcase
    end
  end

  // Wishbone slave: one wait state, unmapped reads return zero.
  always @(posedge clock) begin
    if (rst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h0;
      sblk_q   <= `MBS_CTRL_RESET;
    end else begin
      wb_ack <= wb_hit;
      if (wb_hit && wb_we && wb_sel[0] && wb_adr == `MBS_WB_CTRL)
        sblk_q <= wb_dat_w[`MBS_CTRL_SBLK_BIT];
      if (wb_hit && !wb_we) begin
        case (wb_adr)
          `MBS_WB_CTRL: wb_dat_r <= {30'h0, sblk_q, 1'b0};
          `MBS_WB_STAT: wb_dat_r <= {10'h0, state_q, step_q, 3'h0, rsp_err_q,
                                     speed_q, done_q, phy_q};
          default:      wb_dat_r <= 32'h0;
        endcase
      end else begin
        wb_dat_r <= 32'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/mbs_seq_properties.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mbs_regs.vh"

module mbs_seq_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_ack,
  input wire logic [31:0] wb_dat_r,
  input wire logic [11:0] m_awaddr,
  input wire logic        m_awvalid,
  input wire logic        m_awready,
  input wire logic [31:0] m_wdata,
  input wire logic        m_wvalid,
  input wire logic        m_wready,
  input wire logic        m_bready,
  input wire logic [11:0] m_araddr,
  input wire logic        m_arvalid,
  input wire logic        m_arready,
  input wire logic        m_rvalid,
  input wire logic        m_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Saturating count of cycles since reset release, used for the settle window.
  logic [7:0] up_q;
  always_ff @(posedge clock) begin
    if (rst) up_q <= 8'h00;
    else if (up_q != 8'hFF) up_q <= up_q + 8'h01;
  end
  a_settle_first: assert property (m_awvalid |-> up_q >= `MBS_SETTLE_CYC - 2)
    else $error("early write");
  a_probe_loc: assert property (m_awvalid && m_awaddr == `MBS_MDIO_CTRL
    && m_wdata[`MBS_MDIO_OP_POS+:2] == `MBS_MDIO_OP_RD
    |-> m_wdata[`MBS_MDIO_PHY_POS+:5] == `MBS_PHY_LOC) else $error("probe loc");
  a_aw_w_pair: assert property ($rose(m_awvalid) |-> $rose(m_wvalid))
    else $error("aw w split");
  a_aw_hold: assert property (m_awvalid && !m_awready |=> m_awvalid && $stable(m_awaddr))
    else $error("aw dropped");
  a_w_hold: assert property (m_wvalid && !m_wready |=> m_wvalid && $stable(m_wdata))
    else $error("w dropped");
  a_ar_hold: assert property (m_arvalid && !m_arready |=> m_arvalid && $stable(m_araddr))
    else $error("ar dropped");
  a_one_access: assert property ((m_bready || m_rready) |-> !m_awvalid && !m_arvalid)
    else $error("overlap");
  a_wb_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
    else $error("ack timing");
  a_wb_data_idle: assert property (!wb_ack |-> wb_dat_r == 32'h00000000)
    else $error("data not idle");
  c_write: cover property (m_awvalid && m_awready);
  c_read: cover property (m_rvalid && m_rready);
  c_bus: cover property (wb_ack);
endmodule

bind mbs_sequencer mbs_seq_props u_props (.*);
`default_nettype wire

/* File: tb/mbs_mac_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mbs_regs.vh"

module mbs_mac_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        phy_present,
  input  wire logic [3:0]  lat,
  input  wire logic [11:0] m_awaddr,
  input  wire logic        m_awvalid,
  output var  logic        m_awready,
  input  wire logic [31:0] m_wdata,
  input  wire logic        m_wvalid,
  output var  logic        m_wready,
  output wire logic [1:0]  m_bresp,
  output var  logic        m_bvalid,
  input  wire logic        m_bready,
  input  wire logic [11:0] m_araddr,
  input  wire logic        m_arvalid,
  output var  logic        m_arready,
  output wire logic [31:0] m_rdata,
  output wire logic [1:0]  m_rresp,
  output var  logic        m_rvalid,
  input  wire logic        m_rready
);
  logic [31:0] mem [0:1023];
  logic [15:0] phyreg [0:31];
  logic [31:0] rd_q;
  logic [3:0]  cnt;
  int          n_mode = 0;
  int          n_mdio_wr = 0;
  wire  [4:0]  last_reg = mem[`MBS_MDIO_CTRL >> 2][`MBS_MDIO_REG_POS+:5];
  assign m_bresp = 2'h0;
  assign m_rresp = 2'h0;
  // Released read data shows the inverse so a stale value never passes as valid.
  assign m_rdata = m_rvalid ? rd_q : ~rd_q;
  function automatic logic [31:0] rd_val(input logic [11:0] a);
    if (a == `MBS_MDIO_CTRL) return 32'h00000080;
    if (a == `MBS_PTP_STAT) return 32'h00000001;
    if (a != `MBS_MDIO_RX) return mem[a[11:2]];
    if (last_reg == `MBS_PRB_REG) return phy_present ? 32'h00000000 : 32'h0000FFFF;
    if (last_reg == `MBS_STS_REG) return 32'h00000020;
    return {16'h0000, phyreg[last_reg]};
  endfunction
  always_ff @(posedge clock) begin
    m_awready <= 1'b0;
    m_wready <= 1'b0;
    m_arready <= 1'b0;
    if (rst) begin
      m_bvalid <= 1'b0;
      m_rvalid <= 1'b0;
      cnt <= 4'h0;
    end else begin
      if (m_bvalid && m_bready) m_bvalid <= 1'b0;
      if (m_rvalid && m_rready) m_rvalid <= 1'b0;
      if (m_awvalid && m_awready) begin
        m_bvalid <= 1'b1;
        mem[m_awaddr[11:2]] <= m_wdata;
        if (m_awaddr == `MBS_FILT_MODE) n_mode <= n_mode + 1;
        if (m_awaddr == `MBS_MDIO_CTRL && m_wdata[`MBS_MDIO_OP_POS+:2] == `MBS_MDIO_OP_WR) begin
          phyreg[m_wdata[`MBS_MDIO_REG_POS+:5]] <= mem[`MBS_MDIO_TX >> 2][15:0];
          n_mdio_wr <= n_mdio_wr + 1;
        end
      end
      if (m_arvalid && m_arready) begin
        m_rvalid <= 1'b1;
        rd_q <= rd_val(m_araddr);
      end
      if (((m_awvalid && m_wvalid) || m_arvalid) && !m_awready && !m_arready
          && !m_bvalid && !m_rvalid) begin
        if (cnt < lat) cnt <= cnt + 4'h1;
        else begin
          cnt <= 4'h0;
          m_awready <= m_awvalid;
          m_wready <= m_awvalid;
          m_arready <= !m_awvalid;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/mac_phy_bringup_sequencer_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mbs_regs.vh"

module mac_phy_bringup_sequencer_bench;
  logic        clock, rst, update_speed, serial_command, phy_present;
  logic        wb_cyc, wb_stb, wb_we;
  logic [1:0]  mac_speed;
  logic [3:0]  lat, wb_sel;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat_w, q;
  wire  [31:0] wb_dat_r, m_wdata, m_rdata;
  wire  [11:0] m_awaddr, m_araddr;
  wire  [1:0]  m_bresp, m_rresp;
  wire         wb_ack, serial_response, m_awvalid, m_awready, m_wvalid, m_wready;
  wire         m_bvalid, m_bready, m_arvalid, m_arready, m_rvalid, m_rready;
  int          errors = 0;
  int          n_tests = 0;

  mbs_sequencer DUT (.*);
  mbs_mac_model u_mac (.*);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic complete_run;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} <= {2'h3, we, a, d, 4'hF};
    for (i = 0; i < 50 && wb_ack !== 1'b1; i++) @(posedge clock);
    if (i == 50) begin
      errors++;
      complete_run();
    end
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // Waits for the closing filter-mode write, the last access of each pass.
  task automatic wait_mode(input int n);
    int i;
    for (i = 0; i < 30000 && u_mac.n_mode == n; i++) @(posedge clock);
    if (i == 30000) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic ser(input logic we, input logic [11:0] a, input logic [31:0] d);
    logic [45:0] f;
    int i;
    f = {1'b1, we, a, d};
    for (i = 45; i >= 0; i--) @(posedge clock) serial_command <= f[i];
    @(posedge clock) serial_command <= 1'b0;
    for (i = 0; i < 3000 && serial_response !== 1'b1; i++) @(posedge clock);
    if (i == 3000) begin
      errors++;
      complete_run();
    end
    for (i = 0; i < 32; i++) @(posedge clock) q = {q[30:0], serial_response};
  endtask

  task automatic t_bringup;
    wait_mode(0);
    chk(u_mac.mem[`MBS_MDIO_CFG >> 2][`MBS_MDIO_EN_BIT], 32'h1);
    chk(32'(u_mac.phyreg[`MBS_ADV_REG]), `MBS_ADV_1G);
    chk(32'(u_mac.phyreg[`MBS_GIG_REG]), `MBS_GIG_ADV_1G);
    chk(32'(u_mac.phyreg[`MBS_CTL_REG]), `MBS_PHY_RST_AN);
    chk(u_mac.mem[`MBS_MAC_SPEED >> 2], 32'(2'h2) << `MBS_SPEED_POS);
    chk(u_mac.mem[`MBS_FC_TX >> 2], `MBS_FC_OFF);
    chk(u_mac.mem[`MBS_FC_RX >> 2], `MBS_FC_OFF);
    for (int i = 3; i < 6; i++) chk(u_mac.mem[(`MBS_FILT_BASE >> 2) + i], `MBS_FILT_MASK);
    chk(u_mac.mem[`MBS_FILT_MODE >> 2][`MBS_PROMISC_BIT], 32'h1);
    wb(1'b0, `MBS_WB_STAT, 32'h0);
    chk(q[3:0], 32'hB);
    $display("test bringup done");
  endtask

  // The pin request with no PHY: probe only, no MDIO writes, filter not promiscuous.
  task automatic t_pin_update;
    int m, w;
    m = u_mac.n_mode;
    w = u_mac.n_mdio_wr;
    @(posedge clock);
    phy_present <= 1'b0;
    mac_speed <= 2'h1;
    repeat (4) @(posedge clock) update_speed <= 1'b1;
    @(posedge clock) update_speed <= 1'b0;
    wait_mode(m);
    chk(u_mac.n_mdio_wr, w);
    chk(u_mac.mem[`MBS_MAC_SPEED >> 2], 32'(2'h1) << `MBS_SPEED_POS);
    chk(u_mac.mem[`MBS_FILT_MODE >> 2][`MBS_PROMISC_BIT], 32'h0);
    wb(1'b0, `MBS_WB_STAT, 32'h0);
    chk(q[3:0], 32'h6);
    $display("test pin update done");
  endtask

  task automatic t_ctrl_update;
    int m;
    m = u_mac.n_mode;
    @(posedge clock);
    phy_present <= 1'b1;
    mac_speed <= 2'h0;
    lat <= 4'h3;
    wb(1'b1, `MBS_WB_CTRL, 32'h1);
    wait_mode(m);
    chk(32'(u_mac.phyreg[`MBS_ADV_REG]), `MBS_ADV_10);
    chk(u_mac.mem[`MBS_MAC_SPEED >> 2], 32'h0);
    wb(1'b0, `MBS_WB_CTRL, 32'h0);
    chk(q[`MBS_CTRL_UPD_BIT], 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    $display("test register update done");
  endtask

  task automatic t_serial;
    wb(1'b1, `MBS_WB_CTRL, 32'h2);
    wb(1'b0, `MBS_WB_CTRL, 32'h0);
    chk(q, 32'h2);
    wb(1'b1, `MBS_WB_CTRL, 32'h0);
    ser(1'b1, 12'h7F0, 32'hA5C30F96);
    chk(q, 32'h0);
    chk(u_mac.mem[12'h7F0 >> 2], 32'hA5C30F96);
    ser(1'b0, 12'h7F0, 32'h0);
    chk(q, 32'hA5C30F96);
    $display("test serial done");
  endtask

  initial begin
    {rst, update_speed, serial_command, phy_present, wb_cyc, wb_stb, wb_we} = 7'h49;
    {mac_speed, lat, wb_sel, wb_adr, wb_dat_w} = {2'h2, 4'h0, 4'h0, 8'h00, 32'h0};
    q = 32'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_bringup();
    t_pin_update();
    t_ctrl_update();
    t_serial();
    complete_run();
  end
endmodule
`default_nettype wire
